// File: bench/fcal_prog.sv
`timescale 1ns/1ns
`default_nettype none
// Programmer issuing a full erase, plus the erase completion it signals DONE_DLY clocks after erase_start
module fcal_prog #(
   parameter int unsigned DONE_DLY = 5
) (
   input wire logic ref_clk,
   input wire logic go,
   input wire logic erase_start,
   output logic erase_req,
   output logic erase_done
);
   initial begin
      erase_req = 1'b0;
      erase_done = 1'b0;
   end
   always @(posedge go) begin
      erase_req = 1'b1;
      for (int i = 0; i < 10 && erase_start !== 1'b1; i++) begin
         @(posedge ref_clk);
         #1;
      end
      erase_req = 1'b0;
      if (erase_start === 1'b1) begin
         repeat (DONE_DLY) @(posedge ref_clk);
         #1 erase_done = 1'b1;
         @(posedge ref_clk);
         #1 erase_done = 1'b0;
      end
   end
endmodule : fcal_prog
`default_nettype wire

// File: bench/fcal_properties.sv
`timescale 1ns/1ns
`default_nettype none
module fcal_properties (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic cfg_rd_en,
   input wire logic cfg_rd_valid,
   input wire logic acc_valid,
   input wire logic acc_from_dbg,
   input wire logic acc_write,
   input wire logic acc_fuse_cmd,
   input wire logic [2:0] acc_section,
   input wire logic acc_done,
   input wire logic acc_grant,
   input wire logic [7:0] acc_rd_data,
   input wire logic erase_done,
   input wire logic erase_start,
   input wire logic erase_busy,
   input wire logic cpu_run,
   input wire logic regulator_sink_enable,
   input wire logic [16:0] boot_region_end,
   input wire logic [16:0] code_region_end,
   input wire logic locked,
   input wire logic debug_memory_lockout
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   rd_answer_a: assert property (cfg_rd_valid == $past(cfg_rd_en))
      else $error("read answer timing wrong");
   acc_answer_a: assert property (acc_valid |=> acc_done)
      else $error("access answer missing");
   denied_zero_a: assert property (acc_done && !acc_grant |-> acc_rd_data == 8'h00)
      else $error("denied access returned data");
   dbg_read_locked_a: assert property (acc_valid && acc_from_dbg && !acc_write && locked
      |=> acc_done && !acc_grant)
      else $error("locked debug read granted");
   signature_row_write_a: assert property (acc_valid && acc_write && acc_section == 3'h3
      |=> !acc_grant)
      else $error("signature row write granted");
   boot_row_b_dbg_a: assert property (acc_valid && acc_from_dbg && acc_section == 3'h5
      |=> !acc_grant)
      else $error("debug boot row access granted");
   user_row_a_cmd_a: assert property (acc_valid && acc_from_dbg && acc_write && locked
      && !acc_fuse_cmd |=> !acc_grant)
      else $error("locked write without fuse command granted");
   lockout_hold_a: assert property (debug_memory_lockout |=> debug_memory_lockout)
      else $error("lockout cleared");
   erase_gate_a: assert property (erase_start |-> erase_busy && !debug_memory_lockout)
      else $error("erase started under lockout");
   unlock_cause_a: assert property ($fell(locked) && $past(cpu_run)
      |-> $past(erase_done))
      else $error("unlock without erase");
   cfg_hold_a: assert property ($past(cpu_run) |-> $stable({boot_region_end,
      code_region_end, regulator_sink_enable}))
      else $error("configuration changed after start");
   run_hold_a: assert property (cpu_run |-> ##1 cpu_run [*2])
      else $error("cpu run dropped");
   cover property (erase_start);
   cover property (acc_done && acc_grant);
   cover property ($fell(locked));
endmodule : fcal_properties
bind fuse_config_and_access_lock fcal_properties u_props (.*);
`default_nettype wire

// File: bench/fuse_config_and_access_lock_test.sv
`timescale 1ns/1ns
`default_nettype none
module fuse_config_and_access_lock_test;
   logic ref_clk = 0, nrst = 0, go = 0;
   logic [7:0] fuse_startup_cfg = 0, fuse_code_size = 0, fuse_boot_size = 0;
   logic [15:0] fuse_prot_cfg = 0;
   logic [31:0] fuse_lock_key = 0;
   logic cfg_rd_en = 0, cfg_rd_from_dbg = 0;
   logic [3:0] cfg_rd_addr = 0;
   logic acc_valid = 0, acc_from_dbg = 0, acc_write = 0, acc_fuse_cmd = 0;
   logic [2:0] acc_section = 0;
   logic [16:0] cpu_pc_byte = 0;
   logic [7:0] mem_rd_data = 8'ha5;
   logic cfg_rd_valid, acc_done, acc_grant, erase_req, erase_done, erase_start, erase_busy;
   logic cpu_run, regulator_sink_enable, locked, debug_memory_lockout;
   logic [7:0] cfg_rd_data, acc_rd_data;
   logic [16:0] boot_region_end, code_region_end;
   int mismatches = 0, n_compared = 0, cyc = 0;

   fuse_config_and_access_lock #(.MS_CYCLES(4)) dut (.*);
   fcal_prog prog (.ref_clk, .go, .erase_start, .erase_req, .erase_done);

   always #10 ref_clk = ~ref_clk;

   task end_sim;
      if (mismatches == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         end_sim;
      end
   end

   task chk(input logic [16:0] got, input logic [16:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task step;
      @(posedge ref_clk);
      #1;
   endtask : step

   task boot(input logic [7:0] st, cs, bs, input logic [15:0] pc, input logic [31:0] key);
      nrst = 0;
      {fuse_startup_cfg, fuse_code_size, fuse_boot_size} = {st, cs, bs};
      {fuse_prot_cfg, fuse_lock_key} = {pc, key};
      repeat (16) step;
      nrst = 1;
   endtask : boot

   task wait_run;
      for (int n = 0; n < 40 && cpu_run !== 1'b1; n++) step;
   endtask : wait_run

   task rd(input logic [3:0] a, input logic dbg, input logic [7:0] exp);
      {cfg_rd_en, cfg_rd_addr, cfg_rd_from_dbg} = {1'b1, a, dbg};
      step;
      cfg_rd_en = 0;
      chk(cfg_rd_valid, 1);
      chk(cfg_rd_data, exp);
   endtask : rd

   task acc(input logic dbg, wr, fc, input logic [2:0] sec, input logic [16:0] pc, input logic g);
      {acc_valid, acc_from_dbg, acc_write, acc_fuse_cmd} = {1'b1, dbg, wr, fc};
      {acc_section, cpu_pc_byte} = {sec, pc};
      step;
      acc_valid = 0;
      chk(acc_done, 1);
      chk(acc_grant, g);
      chk(acc_rd_data, (g && !wr) ? 8'ha5 : 8'h00);
   endtask : acc

   task t_lockout;
      boot(8'h0b, 8'h10, 8'h04, 16'hb452, 32'h0);
      step;
      chk(regulator_sink_enable, 1);
      chk(code_region_end, 17'h02000);
      chk(boot_region_end, 17'h00800);
      chk(debug_memory_lockout, 1);
      repeat (14) step;
      chk(cpu_run, 0);
      for (int n = 0; n < 6 && cpu_run !== 1'b1; n++) step;
      chk(cpu_run, 1);
      acc(0, 1, 0, 3'h0, 17'h01000, 0);
      acc(0, 1, 0, 3'h0, 17'h00100, 1);
      acc(1, 0, 0, 3'h0, 0, 0);
      acc(0, 0, 0, 3'h5, 17'h007ff, 1);
      acc(0, 0, 0, 3'h5, 17'h00800, 0);
      rd(fcal_pkg::OFS_PROT_HI, 1, 8'h00);
      rd(fcal_pkg::OFS_PROT_HI, 0, 8'hb4);
      rd(fcal_pkg::OFS_PROT_LO, 0, 8'h52);
      rd(4'h3, 0, 8'h00);
      go = 1;
      repeat (12) step;
      go = 0;
      chk(erase_busy, 0);
      chk(locked, 1);
      chk(debug_memory_lockout, 1);
   endtask : t_lockout

   task t_locked;
      boot(8'h01, 8'h00, 8'h00, 16'h0003, 32'h5cc5c55d);
      wait_run;
      chk(debug_memory_lockout, 0);
      chk(locked, 1);
      rd(fcal_pkg::OFS_STARTUP, 1, 8'h00);
      rd(fcal_pkg::OFS_STARTUP, 0, 8'h01);
      acc(1, 1, 1, 3'h4, 0, 1);
      acc(1, 1, 0, 3'h4, 0, 0);
      acc(1, 0, 1, 3'h4, 0, 0);
      acc(1, 1, 1, 3'h0, 0, 0);
      acc(0, 1, 0, 3'h2, 0, 1);
      go = 1;
      step;
      go = 0;
      for (int n = 0; n < 20 && locked !== 1'b0; n++) step;
      chk(locked, 0);
      chk(erase_busy, 0);
      acc(1, 0, 0, 3'h0, 0, 1);
      acc(1, 1, 0, 3'h3, 0, 0);
      acc(1, 1, 0, 3'h6, 0, 1);
      acc(0, 1, 0, 3'h6, 0, 0);
      acc(0, 0, 0, 3'h3, 0, 1);
   endtask : t_locked

   task t_unlocked;
      boot(8'h00, 8'h00, 8'h00, 16'hb452, 32'h5cc5c55c);
      step;
      chk(cpu_run, 1);
      chk(regulator_sink_enable, 0);
      chk(boot_region_end, 17'h10000);
      chk(code_region_end, 17'h10000);
      chk(locked, 0);
      chk(debug_memory_lockout, 0);
      fuse_boot_size = 8'h01;
      step;
      chk(boot_region_end, 17'h10000);
      acc(1, 0, 0, 3'h2, 0, 1);
      boot(8'h00, 8'h00, 8'h00, 16'hb451, 32'h0);
      step;
      chk(locked, 1);
      chk(debug_memory_lockout, 0);
      acc(1, 0, 0, 3'h2, 0, 0);
      boot(8'h00, 8'h00, 8'h00, 16'hb442, 32'h0);
      step;
      chk(debug_memory_lockout, 0);
   endtask : t_unlocked

   initial begin
      t_lockout;
      t_locked;
      t_unlocked;
      end_sim;
   end
endmodule : fuse_config_and_access_lock_test
`default_nettype wire

// File: hw/fcal_acc_if.sv
`timescale 1ns/1ns
`default_nettype none
interface fcal_acc_if;
   logic locked;
   logic lockout;
   logic from_dbg;
   logic write;
   logic fuse_cmd;
   logic in_boot;
   logic [2:0] section;
   logic grant;

   modport top (output locked, output lockout, output from_dbg, output write,
      output fuse_cmd, output in_boot, output section, input grant);
   modport matrix (input locked, input lockout, input from_dbg, input write,
      input fuse_cmd, input in_boot, input section, output grant);
endinterface : fcal_acc_if
`default_nettype wire

// File: hw/fcal_access_matrix.sv
`timescale 1ns/1ns
`default_nettype none
// Decides whether one memory access may proceed
module fcal_access_matrix (
   fcal_acc_if.matrix acc
);
   fcal_pkg::fcal_section_t sec;
   logic nvm_sec;

   always_comb begin
      sec = fcal_pkg::fcal_section_t'(acc.section);
      nvm_sec = !(sec == fcal_pkg::SEC_SRAM || sec == fcal_pkg::SEC_IO);
      acc.grant = 1'b1;
      if (sec == fcal_pkg::SEC_BOOT_ROW_B && (acc.from_dbg || !acc.in_boot)) begin
         acc.grant = 1'b0;
      end else if (!acc.from_dbg) begin
         if (acc.write && (sec == fcal_pkg::SEC_SIGNATURE_ROW || sec == fcal_pkg::SEC_FUSES)) begin
            acc.grant = 1'b0;
         end else if (acc.write && acc.lockout && nvm_sec && !acc.in_boot) begin
            acc.grant = 1'b0;
         end
      end else if (acc.lockout && nvm_sec) begin
         acc.grant = 1'b0;
      end else if (acc.locked) begin
         // Only a fuse write command may reach the user row
         acc.grant = acc.write && sec == fcal_pkg::SEC_USER_ROW_A && acc.fuse_cmd;
      end else if (acc.write && sec == fcal_pkg::SEC_SIGNATURE_ROW) begin
         acc.grant = 1'b0;
      end
   end
endmodule : fcal_access_matrix
`default_nettype wire

// File: hw/fcal_ms_tick.sv
`timescale 1ns/1ns
`default_nettype none
// Emits a one-cycle pulse every CYCLES clocks while run is high
module fcal_ms_tick #(
   parameter int unsigned CYCLES = fcal_pkg::MS_CYCLES
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic run,
   output logic tick
);
   typedef struct packed {
      logic [31:0] count;
      logic tick;
   } fcal_tick_st_t;

   fcal_tick_st_t st;
   fcal_tick_st_t next_st;

   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (!run) begin
         next_st.count = 32'h0;
      end else if (st.count >= 32'(CYCLES - 1)) begin
         next_st.count = 32'h0;
         next_st.tick = 1'b1;
      end else begin
         next_st.count = st.count + 32'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick = st.tick;
endmodule : fcal_ms_tick
`default_nettype wire

// File: hw/fcal_pkg.sv
package fcal_pkg;

   // Clock and time base
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned MS_NS = 1000000;
   localparam int unsigned MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Fuse byte offsets as seen on the configuration read port
   localparam logic [3:0] OFS_STARTUP = 4'h6;
   localparam logic [3:0] OFS_CODE_SIZE = 4'h7;
   localparam logic [3:0] OFS_BOOT_SIZE = 4'h8;
   localparam logic [3:0] OFS_PROT_LO = 4'ha;
   localparam logic [3:0] OFS_PROT_HI = 4'hb;

   // Field positions
   localparam int unsigned USB_SINK_BIT = 3;
   localparam int unsigned SUT_MSB = 2;
   localparam int unsigned PROT_KEY_MSB = 15;
   localparam int unsigned PROT_KEY_LSB = 4;
   localparam int unsigned LEVEL_MSB = 1;

   // Field encodings
   localparam logic [11:0] PROT_KEY_ACTIVE = 12'hb45;
   localparam logic [1:0] LEVEL_LOCKOUT = 2'h2;
   localparam logic [1:0] LEVEL_BASIC = 2'h3;
   localparam logic [31:0] UNLOCK_KEY = 32'h5cc5c55c;
   localparam logic [7:0] SIZE_ZERO = 8'h00;
   localparam logic [2:0] SUT_ZERO = 3'h0;

   // Flash geometry: 512-byte blocks, byte addresses 17 bits wide
   localparam int unsigned BLOCK_SHIFT = 9;
   localparam int unsigned FLASH_AW = 17;
   localparam logic [16:0] FLASH_BYTES = 17'h10000;

   // Values for refused reads and for the last startup delay step
   localparam logic [7:0] DENIED_DATA = 8'h00;
   localparam logic [6:0] DELAY_ONE = 7'h01;

   typedef enum logic [2:0] {
      SEC_FLASH = 3'b000,
      SEC_SRAM = 3'b001,
      SEC_EEPROM = 3'b010,
      SEC_SIGNATURE_ROW = 3'b011,
      SEC_USER_ROW_A = 3'b100,
      SEC_BOOT_ROW_B = 3'b101,
      SEC_FUSES = 3'b110,
      SEC_IO = 3'b111
   } fcal_section_t;

   typedef enum logic [1:0] {
      PH_INIT = 2'b00,
      PH_DELAY = 2'b01,
      PH_RUN = 2'b10
   } fcal_phase_t;

   function automatic logic [6:0] fcal_startup_ms(input logic [2:0] code);
      fcal_startup_ms = (code == SUT_ZERO) ? 7'h00 : 7'(7'h01 << (code - 3'h1));
   endfunction : fcal_startup_ms

   function automatic logic [16:0] fcal_blocks_to_bytes(input logic [7:0] blocks);
      fcal_blocks_to_bytes = {blocks, 9'h000};
   endfunction : fcal_blocks_to_bytes

endpackage : fcal_pkg

// File: hw/fuse_config_and_access_lock.sv
`timescale 1ns/1ns
`default_nettype none
module fuse_config_and_access_lock #(
   parameter int unsigned MS_CYCLES = fcal_pkg::MS_CYCLES
) (
   input wire logic ref_clk,
   input wire logic nrst,
   // Fuse array contents
   input wire logic [7:0] fuse_startup_cfg,
   input wire logic [7:0] fuse_code_size,
   input wire logic [7:0] fuse_boot_size,
   input wire logic [15:0] fuse_prot_cfg,
   input wire logic [31:0] fuse_lock_key,
   // Configuration byte read port
   input wire logic cfg_rd_en,
   input wire logic [3:0] cfg_rd_addr,
   input wire logic cfg_rd_from_dbg,
   output logic cfg_rd_valid,
   output logic [7:0] cfg_rd_data,
   // Memory access check
   input wire logic acc_valid,
   input wire logic acc_from_dbg,
   input wire logic acc_write,
   input wire logic acc_fuse_cmd,
   input wire logic [2:0] acc_section,
   input wire logic [16:0] cpu_pc_byte,
   input wire logic [7:0] mem_rd_data,
   output logic acc_done,
   output logic acc_grant,
   output logic [7:0] acc_rd_data,
   // Full device erase
   input wire logic erase_req,
   input wire logic erase_done,
   output logic erase_start,
   output logic erase_busy,
   // Decoded configuration
   output logic cpu_run,
   output logic regulator_sink_enable,
   output logic [16:0] boot_region_end,
   output logic [16:0] code_region_end,
   output logic locked,
   output logic debug_memory_lockout
);

   typedef struct packed {
      fcal_pkg::fcal_phase_t phase;
      logic [6:0] delay_left;
      logic [7:0] startup_and_usb_sink_config;
      logic [7:0] code_region_size;
      logic [7:0] boot_region_size;
      logic [15:0] debug_port_protection_config;
      logic locked;
      logic lockout;
      logic erase_busy;
      logic erase_start;
      logic cpu_run;
      logic sink_en;
      logic [16:0] boot_end;
      logic [16:0] code_end;
      logic acc_done;
      logic acc_grant;
      logic [7:0] acc_rd_data;
      logic cfg_rd_valid;
      logic [7:0] cfg_rd_data;
   } fcal_state_t;

   fcal_state_t st;
   fcal_state_t next_st;

   logic ms_tick;
   logic protection_key_match;
   logic [1:0] prot_level;
   logic in_boot;
   logic [7:0] cfg_byte;

   fcal_acc_if acc_bus ();

   fcal_ms_tick #(
      .CYCLES(MS_CYCLES)
   ) u_ms_tick (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .run(st.phase == fcal_pkg::PH_DELAY),
      .tick(ms_tick)
   );

   fcal_access_matrix u_matrix (
      .acc(acc_bus)
   );

   // Fuse decode from the raw array, used only while initialising
   assign protection_key_match =
      fuse_prot_cfg[fcal_pkg::PROT_KEY_MSB:fcal_pkg::PROT_KEY_LSB]
      == fcal_pkg::PROT_KEY_ACTIVE;
   assign prot_level = fuse_prot_cfg[fcal_pkg::LEVEL_MSB:0];

   // Boot region is the span below the boot end address
   assign in_boot = cpu_pc_byte < st.boot_end;

   assign acc_bus.locked = st.locked;
   assign acc_bus.lockout = st.lockout;
   assign acc_bus.from_dbg = acc_from_dbg;
   assign acc_bus.write = acc_write;
   assign acc_bus.fuse_cmd = acc_fuse_cmd;
   assign acc_bus.in_boot = in_boot;
   assign acc_bus.section = acc_section;

   // Configuration byte mux; unmapped offsets read zero
   always_comb begin
      cfg_byte = fcal_pkg::DENIED_DATA;
      case (cfg_rd_addr)
         fcal_pkg::OFS_STARTUP: begin
            cfg_byte = st.startup_and_usb_sink_config;
         end
         fcal_pkg::OFS_CODE_SIZE: begin
            cfg_byte = st.code_region_size;
         end
         fcal_pkg::OFS_BOOT_SIZE: begin
            cfg_byte = st.boot_region_size;
         end
         fcal_pkg::OFS_PROT_LO: begin
            cfg_byte = st.debug_port_protection_config[7:0];
         end
         fcal_pkg::OFS_PROT_HI: begin
            cfg_byte = st.debug_port_protection_config[15:8];
         end
         default: begin
            cfg_byte = fcal_pkg::DENIED_DATA;
         end
      endcase
   end

   always_comb begin
      next_st = st;
      next_st.erase_start = 1'b0;
      next_st.acc_done = 1'b0;
      next_st.cfg_rd_valid = 1'b0;

      unique case (st.phase)
         fcal_pkg::PH_INIT: begin
            // One-time capture of every fuse field
            next_st.startup_and_usb_sink_config = fuse_startup_cfg;
            next_st.code_region_size = fuse_code_size;
            next_st.boot_region_size = fuse_boot_size;
            next_st.debug_port_protection_config = fuse_prot_cfg;
            next_st.sink_en = fuse_startup_cfg[fcal_pkg::USB_SINK_BIT];
            next_st.locked = fuse_lock_key != fcal_pkg::UNLOCK_KEY;
            // Level 3 and reserved codes never set the lockout; only the lock key decides locked
            next_st.lockout = protection_key_match
               && prot_level == fcal_pkg::LEVEL_LOCKOUT
               && fuse_lock_key != fcal_pkg::UNLOCK_KEY;
            if (fuse_boot_size == fcal_pkg::SIZE_ZERO) begin
               next_st.boot_end = fcal_pkg::FLASH_BYTES;
            end else begin
               next_st.boot_end = fcal_pkg::fcal_blocks_to_bytes(fuse_boot_size);
            end
            if (fuse_code_size == fcal_pkg::SIZE_ZERO) begin
               next_st.code_end = next_st.boot_end;
            end else begin
               next_st.code_end = fcal_pkg::fcal_blocks_to_bytes(fuse_code_size);
            end
            next_st.delay_left = fcal_pkg::fcal_startup_ms(
               fuse_startup_cfg[fcal_pkg::SUT_MSB:0]);
            if (fuse_startup_cfg[fcal_pkg::SUT_MSB:0] == fcal_pkg::SUT_ZERO) begin
               next_st.phase = fcal_pkg::PH_RUN;
               next_st.cpu_run = 1'b1;
            end else begin
               next_st.phase = fcal_pkg::PH_DELAY;
            end
         end
         fcal_pkg::PH_DELAY: begin
            if (ms_tick) begin
               if (st.delay_left == fcal_pkg::DELAY_ONE) begin
                  next_st.phase = fcal_pkg::PH_RUN;
                  next_st.cpu_run = 1'b1;
               end
               next_st.delay_left = st.delay_left - 7'h01;
            end
         end
         fcal_pkg::PH_RUN: begin
            // Erase requests are honoured only once running
            if (erase_req && !st.erase_busy && !st.lockout) begin
               next_st.erase_busy = 1'b1;
               next_st.erase_start = 1'b1;
            end
            if (st.erase_busy && erase_done) begin
               next_st.erase_busy = 1'b0;
               // Lockout stays set whatever the erase does
               next_st.locked = 1'b0;
            end
         end
         default: begin
            next_st.phase = fcal_pkg::PH_INIT;
         end
      endcase

      // Access answers: refused reads finish quietly with dummy data
      if (acc_valid) begin
         next_st.acc_done = 1'b1;
         next_st.acc_grant = acc_bus.grant && st.phase == fcal_pkg::PH_RUN;
         if (acc_bus.grant && st.phase == fcal_pkg::PH_RUN && !acc_write) begin
            next_st.acc_rd_data = mem_rd_data;
         end else begin
            next_st.acc_rd_data = fcal_pkg::DENIED_DATA;
         end
      end

      // Fuse bytes are hidden from the debug port while locked
      if (cfg_rd_en) begin
         next_st.cfg_rd_valid = 1'b1;
         if (cfg_rd_from_dbg && (st.locked || st.lockout)) begin
            next_st.cfg_rd_data = fcal_pkg::DENIED_DATA;
         end else begin
            next_st.cfg_rd_data = cfg_byte;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
         st.phase <= fcal_pkg::PH_INIT;
         st.locked <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign cfg_rd_valid = st.cfg_rd_valid;
   assign cfg_rd_data = st.cfg_rd_data;
   assign acc_done = st.acc_done;
   assign acc_grant = st.acc_grant;
   assign acc_rd_data = st.acc_rd_data;
   assign erase_start = st.erase_start;
   assign erase_busy = st.erase_busy;
   assign cpu_run = st.cpu_run;
   assign regulator_sink_enable = st.sink_en;
   assign boot_region_end = st.boot_end;
   assign code_region_end = st.code_end;
   assign locked = st.locked;
   assign debug_memory_lockout = st.lockout;

endmodule : fuse_config_and_access_lock
`default_nettype wire
